// file: design/tcrc_pkg.sv
package tcrc_pkg;
  // Byte map of the readout registers
  localparam logic [7:0] ADDR_UPPER_MSB = 8'ha0;
  localparam logic [7:0] ADDR_UPPER_LSB = 8'ha1;
  localparam logic [7:0] ADDR_LOWER_MSB = 8'ha2;
  localparam logic [7:0] ADDR_LOWER_LSB = 8'ha3;
  localparam logic [7:0] ADDR_TEMP_MSB = 8'haa;
  localparam logic [7:0] ADDR_TEMP_LSB = 8'hab;

  localparam logic [15:0] UPPER_THR_RESET = 16'h0780;
  localparam logic [15:0] LOWER_THR_RESET = 16'h0500;
  localparam logic [15:0] RESULT_RESET = 16'he200;
  localparam logic [15:0] MASK_13BIT = 16'hfff8;
  localparam logic [15:0] MASK_12BIT = 16'hfff0;
  localparam logic [15:0] MASK_11BIT = 16'hffe0;
  localparam logic [15:0] MASK_10BIT = 16'hffc0;
  localparam logic [1:0] RES_13BIT = 2'h3;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MAX_MS = 200;
  // Longest time: round down
  localparam int CONV_MAX_CYCLES = CONV_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CONV_10BIT_CYCLES = CONV_MAX_CYCLES / 8;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int GLITCH_NS = 50;
  // Least time: round up
  localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_STANDBY = 2'b01,
    ST_CONVERT = 2'b11
  } tcrc_state_t;
endpackage : tcrc_pkg

// file: design/tcrc_glitch_filter.sv
`timescale 1ns/100ps
module tcrc_glitch_filter #(
  parameter int STABLE_CYCLES = tcrc_pkg::GLITCH_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);
  logic sync1_reg;
  logic sync2_reg;
  logic [7:0] cnt_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // A new level must hold for the full window before it is passed on
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= 8'h00;
      o_level <= 1'b1;
    end else if (sync2_reg == o_level) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == 8'(STABLE_CYCLES - 1)) begin
      cnt_reg <= 8'h00;
      o_level <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  property p_glitch_reject;
    @(posedge i_clk) disable iff (i_rst)
    (o_level != $past(o_level)) |-> $past(cnt_reg) == 8'(STABLE_CYCLES - 1);
  endproperty
  a_glitch_reject: assert property (p_glitch_reject)
    else $error("Filtered level changed before the stable window elapsed");
endmodule : tcrc_glitch_filter

// file: design/tcrc_conv_timer.sv
`timescale 1ns/100ps
module tcrc_conv_timer #(
  parameter int BASE_CYCLES = tcrc_pkg::CONV_10BIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [1:0] i_res,
  output logic o_busy,
  output logic o_done
);
  logic [31:0] count_reg;

  // Abort wins over start so a halt always leaves the timer idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg <= 32'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        o_busy <= 1'b0;
      end else if (i_start) begin
        count_reg <= (32'(BASE_CYCLES) << i_res) - 32'h1;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (count_reg == 32'h0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count_reg <= count_reg - 32'h1;
        end
      end
    end
  end

  property p_done_after_busy;
    @(posedge i_clk) disable iff (i_rst)
    o_done |-> $past(o_busy) && !o_busy;
  endproperty
  a_done_after_busy: assert property (p_done_after_busy)
    else $error("Conversion done without a running conversion");
endmodule : tcrc_conv_timer

// file: design/tcrc_result_ctrl.sv
// How it works
// - Two resolution bits pick 10 to 13 bits, LSB 0.5 to 0.0625 degrees.
// - Until configuration is written, conversions run at 13 bits.
// - Each extra resolution bit doubles the conversion time.
// - A 13-bit conversion ends within 200 ms; host waits that long.
// - Nonvolatile auto-convert bit picks converting or standby at power-up.
// - Single-conversion bit picks one-shot or continuous operation.
// - Continuous mode converts back to back until halt, then standby.
// - Begin restarts continuous conversions at any time except the power-up cycle or while halt is set.
// - Single mode converts once, then standby until the next begin.
// - Each result is stored as 16-bit two's complement, bytes at AAh, ABh.
// - Bit 15 is sign; bits 14 to 3 weigh 2^7 down to 2^-4.
// - Result bits 2 to 0 always read zero.
// - Only the selected resolution's top bits hold data; the rest are zero.
// - Encoding matches 3E80h for +125, FFC0h for -0.5, E480h for -55.
// - Threshold writes drop the three LSBs, which read back zero.
// - Thresholds hold factory values 0780h upper and 0500h lower.
// - Result register loads E200h at power-up.
// - A nonvolatile write completes within 10 ms; host waits it out.
// - Serial inputs reject glitches narrower than 50 ns.
`timescale 1ns/100ps
module tcrc_result_ctrl #(
  parameter int CONV_10BIT_CYCLES = tcrc_pkg::CONV_10BIT_CYCLES,
  parameter int NV_WRITE_CYCLES = tcrc_pkg::NV_WRITE_CYCLES,
  parameter int GLITCH_CYCLES = tcrc_pkg::GLITCH_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_SCL_PIN,
  input wire logic i_SDA_PIN,
  output logic o_SCL_FILT,
  output logic o_SDA_FILT,
  input wire logic i_BEGIN_CMD,
  input wire logic i_HALT_CMD,
  input wire logic i_CONVERT_AT_POWERUP,
  input wire logic i_SINGLE_CONVERSION_SELECT,
  input wire logic i_CONFIG_WR,
  input wire logic i_RESOLUTION_SELECT_HI,
  input wire logic i_RESOLUTION_SELECT_LO,
  input wire logic [12:0] i_SENSOR_CODE,
  input wire logic i_REG_WR,
  input wire logic [7:0] i_REG_ADDR,
  input wire logic [7:0] i_REG_WDATA,
  output logic [7:0] o_REG_RDATA,
  output logic [15:0] o_RESULT,
  output logic o_CONV_DONE,
  output logic o_CONVERTING,
  output logic o_NV_BUSY
);
  tcrc_pkg::tcrc_state_t state_reg;
  logic [1:0] res_reg;
  logic [1:0] conv_res_reg;
  logic [15:0] result_reg;
  logic [15:0] upper_threshold_reg;
  logic [15:0] lower_threshold_reg;
  logic [31:0] nv_cnt_reg;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic nv_wr_ok;
  logic thr_hit;
  logic [15:0] cur_mask;

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    case (res)
      2'h0: res_mask = tcrc_pkg::MASK_10BIT;
      2'h1: res_mask = tcrc_pkg::MASK_11BIT;
      2'h2: res_mask = tcrc_pkg::MASK_12BIT;
      default: res_mask = tcrc_pkg::MASK_13BIT;
    endcase
  endfunction : res_mask

  tcrc_glitch_filter #(.STABLE_CYCLES(GLITCH_CYCLES)) u_scl_filt (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_pin(i_SCL_PIN),
    .o_level(o_SCL_FILT)
  );

  tcrc_glitch_filter #(.STABLE_CYCLES(GLITCH_CYCLES)) u_sda_filt (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_pin(i_SDA_PIN),
    .o_level(o_SDA_FILT)
  );

  tcrc_conv_timer #(.BASE_CYCLES(CONV_10BIT_CYCLES)) u_timer (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_start(tmr_start),
    .i_abort(i_HALT_CMD),
    .i_res(res_reg),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // Halt beats begin; a begin during the power-up cycle is dropped
  always_comb begin
    tmr_start = 1'b0;
    if (!i_HALT_CMD) begin
      case (state_reg)
        tcrc_pkg::ST_POWERUP: tmr_start = i_CONVERT_AT_POWERUP;
        tcrc_pkg::ST_STANDBY: tmr_start = i_BEGIN_CMD;
        tcrc_pkg::ST_CONVERT: begin
          tmr_start = i_BEGIN_CMD || (tmr_done && !i_SINGLE_CONVERSION_SELECT);
        end
        default: tmr_start = 1'b0;
      endcase
    end
  end

  assign cur_mask = res_mask(conv_res_reg);
  assign nv_wr_ok = (nv_cnt_reg == 32'h0);
  assign thr_hit = i_REG_WR && (i_REG_ADDR[7:2] == tcrc_pkg::ADDR_UPPER_MSB[7:2]);

  // Power-up cycle samples the auto-convert strap after reset release
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_reg <= tcrc_pkg::ST_POWERUP;
    end else begin
      case (state_reg)
        tcrc_pkg::ST_POWERUP: begin
          state_reg <= tmr_start ? tcrc_pkg::ST_CONVERT : tcrc_pkg::ST_STANDBY;
        end
        tcrc_pkg::ST_STANDBY: begin
          if (tmr_start) begin
            state_reg <= tcrc_pkg::ST_CONVERT;
          end
        end
        tcrc_pkg::ST_CONVERT: begin
          if (i_HALT_CMD) begin
            state_reg <= tcrc_pkg::ST_STANDBY;
          end else if (tmr_done && !tmr_start) begin
            state_reg <= tcrc_pkg::ST_STANDBY;
          end
        end
        default: state_reg <= tcrc_pkg::ST_STANDBY;
      endcase
    end
  end

  // Resolution defaults to 13 bits until configuration is written
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      res_reg <= tcrc_pkg::RES_13BIT;
      conv_res_reg <= tcrc_pkg::RES_13BIT;
    end else begin
      if (i_CONFIG_WR) begin
        res_reg <= {i_RESOLUTION_SELECT_HI, i_RESOLUTION_SELECT_LO};
      end
      if (tmr_start) begin
        conv_res_reg <= res_reg;
      end
    end
  end

  // Result: a completed conversion overwrites any software write
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      result_reg <= tcrc_pkg::RESULT_RESET;
    end else if (tmr_done) begin
      result_reg <= {i_SENSOR_CODE, 3'h0} & cur_mask;
    end else if (i_REG_WR && i_REG_ADDR == tcrc_pkg::ADDR_TEMP_MSB) begin
      result_reg[15:8] <= i_REG_WDATA;
    end else if (i_REG_WR && i_REG_ADDR == tcrc_pkg::ADDR_TEMP_LSB) begin
      result_reg[7:0] <= {i_REG_WDATA[7:3], 3'h0};
    end
  end

  // Threshold writes are refused while a nonvolatile write is running
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      upper_threshold_reg <= tcrc_pkg::UPPER_THR_RESET;
      lower_threshold_reg <= tcrc_pkg::LOWER_THR_RESET;
    end else if (thr_hit && nv_wr_ok) begin
      case (i_REG_ADDR[1:0])
        2'h0: upper_threshold_reg[15:8] <= i_REG_WDATA;
        2'h1: upper_threshold_reg[7:0] <= {i_REG_WDATA[7:3], 3'h0};
        2'h2: lower_threshold_reg[15:8] <= i_REG_WDATA;
        default: lower_threshold_reg[7:0] <= {i_REG_WDATA[7:3], 3'h0};
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      nv_cnt_reg <= 32'h0;
    end else if (thr_hit && nv_wr_ok) begin
      nv_cnt_reg <= 32'(NV_WRITE_CYCLES);
    end else if (!nv_wr_ok) begin
      nv_cnt_reg <= nv_cnt_reg - 32'h1;
    end
  end

  // Read data follows the address one cycle later; unmapped bytes read zero
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_REG_RDATA <= 8'h00;
    end else begin
      case (i_REG_ADDR)
        tcrc_pkg::ADDR_UPPER_MSB: o_REG_RDATA <= upper_threshold_reg[15:8];
        tcrc_pkg::ADDR_UPPER_LSB: o_REG_RDATA <= upper_threshold_reg[7:0];
        tcrc_pkg::ADDR_LOWER_MSB: o_REG_RDATA <= lower_threshold_reg[15:8];
        tcrc_pkg::ADDR_LOWER_LSB: o_REG_RDATA <= lower_threshold_reg[7:0];
        tcrc_pkg::ADDR_TEMP_MSB: o_REG_RDATA <= result_reg[15:8];
        tcrc_pkg::ADDR_TEMP_LSB: o_REG_RDATA <= result_reg[7:0];
        default: o_REG_RDATA <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      o_RESULT <= tcrc_pkg::RESULT_RESET;
      o_CONV_DONE <= 1'b0;
      o_CONVERTING <= 1'b0;
      o_NV_BUSY <= 1'b0;
    end else begin
      o_RESULT <= result_reg;
      o_CONV_DONE <= tmr_done;
      o_CONVERTING <= tmr_busy;
      o_NV_BUSY <= !nv_wr_ok;
    end
  end

  // Helper: cycles spent in the current conversion
  logic [31:0] conv_len_reg;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || tmr_start || !tmr_busy) begin
      conv_len_reg <= 32'h0;
    end else begin
      conv_len_reg <= conv_len_reg + 32'h1;
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  property p_conv_len;
    tmr_done |-> conv_len_reg == (32'(CONV_10BIT_CYCLES) << conv_res_reg);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("Conversion length does not match resolution");

  property p_res_reset;
    $fell(I_SYS_RST) |-> res_reg == tcrc_pkg::RES_13BIT;
  endproperty
  a_res_reset: assert property (p_res_reset)
    else $error("Resolution not 13 bits after reset");

  property p_powerup;
    state_reg == tcrc_pkg::ST_POWERUP && !i_HALT_CMD
      |=> (state_reg == tcrc_pkg::ST_CONVERT) == $past(i_CONVERT_AT_POWERUP);
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("Power-up mode ignores auto-convert bit");

  property p_continuous;
    state_reg == tcrc_pkg::ST_CONVERT && tmr_done && !i_SINGLE_CONVERSION_SELECT && !i_HALT_CMD
      |=> state_reg == tcrc_pkg::ST_CONVERT && tmr_busy;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("Continuous mode did not restart conversion");

  property p_begin;
    i_BEGIN_CMD && !i_HALT_CMD && state_reg != tcrc_pkg::ST_POWERUP
      |=> tmr_busy && state_reg == tcrc_pkg::ST_CONVERT;
  endproperty
  a_begin: assert property (p_begin)
    else $error("Begin command did not start a conversion");

  property p_single;
    tmr_done && i_SINGLE_CONVERSION_SELECT && !i_BEGIN_CMD && !i_HALT_CMD
      |=> state_reg == tcrc_pkg::ST_STANDBY && !tmr_busy;
  endproperty
  a_single: assert property (p_single)
    else $error("Single mode did not return to standby");

  property p_store;
    tmr_done |=> result_reg == ({$past(i_SENSOR_CODE), 3'h0} & $past(cur_mask));
  endproperty
  a_store: assert property (p_store)
    else $error("Stored result does not match masked sensor code");

  property p_low_zero;
    result_reg[2:0] == 3'h0 && upper_threshold_reg[2:0] == 3'h0
      && lower_threshold_reg[2:0] == 3'h0;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("Low three bits not zero");

  property p_factory;
    $fell(I_SYS_RST) |-> result_reg == tcrc_pkg::RESULT_RESET
      && upper_threshold_reg == tcrc_pkg::UPPER_THR_RESET
      && lower_threshold_reg == tcrc_pkg::LOWER_THR_RESET;
  endproperty
  a_factory: assert property (p_factory)
    else $error("Wrong power-up register values");

  property p_nv_lock;
    thr_hit && !nv_wr_ok |=> $stable(upper_threshold_reg) && $stable(lower_threshold_reg);
  endproperty
  a_nv_lock: assert property (p_nv_lock)
    else $error("Threshold changed during nonvolatile write");

  property p_halt;
    i_HALT_CMD && state_reg != tcrc_pkg::ST_POWERUP
      |=> state_reg == tcrc_pkg::ST_STANDBY && !tmr_busy ##1 !tmr_done;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Halt did not stop conversions");

  c_continuous: cover property (tmr_done && !i_SINGLE_CONVERSION_SELECT);
  c_single: cover property (tmr_done && i_SINGLE_CONVERSION_SELECT);
  c_halt_mid: cover property (i_HALT_CMD && tmr_busy);
  c_nv_refused: cover property (thr_hit && !nv_wr_ok);
endmodule : tcrc_result_ctrl

// file: test/tcrc_host_model.sv
`timescale 1ns/100ps
module tcrc_host_model #(
  parameter int CONV_WAIT = 72,
  parameter int NV_WAIT = 18
) (
  output logic o_scl,
  output logic o_sda
);
  // Both lines have pull-ups, so a released line sits high
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end

  task automatic pulse_low(input logic on_sda, input int width_ns);
    if (on_sda) begin
      o_sda = 1'h0;
    end else begin
      o_scl = 1'h0;
    end
    #(width_ns);
    o_scl = 1'h1;
    o_sda = 1'h1;
  endtask : pulse_low
endmodule : tcrc_host_model

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int BASE = 8;
  localparam int NVW = 16;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic scl, sda, scl_f, sda_f, beg, hlt, auto_c, single, cfg_wr, r_hi, r_lo, wr_en;
  logic done, busy_c, nv_busy, seen;
  logic [12:0] code;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] result;
  logic [15:0] exp_q[$];
  logic [12:0] ex_code[3] = '{13'h07d0, 13'h1ff8, 13'h1c90};
  logic [15:0] ex_word[3] = '{16'h3e80, 16'hffc0, 16'he480};
  int num_errors = 0;
  int n_checks = 0;
  int seed = 81;
  int d[4];
  int n;
  int k;

  always #5 clk = ~clk;

  // Slack of a few cycles covers command and result pipeline latency
  tcrc_host_model #(.CONV_WAIT(BASE * 8 + 8), .NV_WAIT(NVW + 2)) host (.o_scl(scl), .o_sda(sda));
  tcrc_result_ctrl #(.CONV_10BIT_CYCLES(BASE), .NV_WRITE_CYCLES(NVW), .GLITCH_CYCLES(5)) uut (
    .I_CLK(clk), .I_SYS_RST(rst), .i_SCL_PIN(scl), .i_SDA_PIN(sda),
    .o_SCL_FILT(scl_f), .o_SDA_FILT(sda_f), .i_BEGIN_CMD(beg), .i_HALT_CMD(hlt),
    .i_CONVERT_AT_POWERUP(auto_c), .i_SINGLE_CONVERSION_SELECT(single),
    .i_CONFIG_WR(cfg_wr), .i_RESOLUTION_SELECT_HI(r_hi), .i_RESOLUTION_SELECT_LO(r_lo),
    .i_SENSOR_CODE(code), .i_REG_WR(wr_en), .i_REG_ADDR(addr), .i_REG_WDATA(wdata),
    .o_REG_RDATA(rdata), .o_RESULT(result), .o_CONV_DONE(done), .o_CONVERTING(busy_c),
    .o_NV_BUSY(nv_busy));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic tick(input int cycles = 1);
    repeat (cycles) @(posedge clk);
    #1;
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
    // Let an edge pass so a following pulse never re-raises in the same step
    tick();
  endtask : pulse

  // Lower bits below the selected resolution are cleared
  function automatic logic [15:0] expect_of(input logic [12:0] c, input int res);
    int v;
    v = int'(c) << 3;
    v = v & ~((1 << (6 - res)) - 1);
    return v[15:0];
  endfunction : expect_of

  task automatic do_reset(input logic auto);
    rst = 1'h1;
    auto_c = auto;
    tick(4);
    rst = 1'h0;
    tick(2);
  endtask : do_reset

  task automatic start_conv(input int res, input logic [12:0] c);
    {r_hi, r_lo} = 2'(res);
    pulse(cfg_wr);
    code = c;
    exp_q.push_back(expect_of(c, res));
    pulse(beg);
  endtask : start_conv

  task automatic wait_done(output int cnt);
    cnt = 0;
    while (done !== 1'h1) begin
      tick();
      cnt++;
      if (cnt > 1000) begin
        num_errors++;
        report_and_stop();
      end
    end
    // The result output settles one cycle after the done pulse
    tick();
    cmp_word(result, exp_q.pop_front());
  endtask : wait_done

  task automatic wait_nv(output int cnt);
    cnt = 0;
    while (nv_busy !== 1'h0) begin
      tick();
      cnt++;
      if (cnt > 1000) begin
        num_errors++;
        report_and_stop();
      end
    end
  endtask : wait_nv

  task automatic quiet(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles) begin
      tick();
      if (done === 1'h1) cnt++;
    end
  endtask : quiet

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    addr = a;
    wdata = dat;
    pulse(wr_en);
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    tick(2);
    cmp_word({8'h00, rdata}, {8'h00, exp});
  endtask : chk_rd

  task automatic watch(input int line, input logic lvl, output logic hit);
    hit = 1'h0;
    repeat (40) begin
      tick();
      if ((line ? sda_f : scl_f) === lvl) hit = 1'h1;
    end
  endtask : watch

  initial begin
    {beg, hlt, cfg_wr, wr_en, r_hi, r_lo} = '0;
    single = 1'h1;
    auto_c = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    code = 13'h0000;
    do_reset(1'h0);
    cmp_word(result, 16'he200);
    chk_rd(8'haa, 8'he2);
    chk_rd(8'ha0, 8'h07);
    chk_rd(8'ha1, 8'h80);
    chk_rd(8'ha2, 8'h05);
    chk_rd(8'ha3, 8'h00);
    cmp_bit(busy_c, 1'h0);
    $display("reset values done");
    code = 13'($random(seed));
    exp_q.push_back(expect_of(code, 3));
    pulse(beg);
    wait_done(n);
    for (k = 0; k < 4; k++) begin
      start_conv(k, 13'($random(seed)));
      wait_done(d[k]);
      cmp_bit(d[k] - d[0] == BASE * ((1 << k) - 1), 1'h1);
    end
    cmp_bit(n == d[3], 1'h1);
    cmp_bit(d[3] <= host.CONV_WAIT, 1'h1);
    quiet(150, n);
    cmp_word(16'(n), 16'h0000);
    for (k = 0; k < 3; k++) begin
      start_conv(3, ex_code[k]);
      wait_done(n);
      cmp_word(result, ex_word[k]);
      chk_rd(8'haa, ex_word[k][15:8]);
      chk_rd(8'hab, ex_word[k][7:0]);
    end
    $display("resolution and format done");
    single = 1'h0;
    start_conv(0, 13'($random(seed)));
    tick(3);
    pulse(beg);
    wait_done(n);
    cmp_bit(n == d[0], 1'h1);
    exp_q.push_back(expect_of(code, 0));
    wait_done(n);
    pulse(hlt);
    quiet(150, n);
    cmp_word(16'(n), 16'h0000);
    cmp_bit(busy_c, 1'h0);
    for (k = 0; k < 2; k++) begin
      single = ~k[0];
      code = 13'($random(seed));
      do_reset(1'h1);
      repeat (k + 1) begin
        exp_q.push_back(expect_of(code, 3));
        wait_done(n);
      end
      if (k == 1) pulse(hlt);
      quiet(150, n);
      cmp_word(16'(n), 16'h0000);
    end
    $display("mode control done");
    wr(8'ha1, 8'hff);
    wr(8'ha0, 8'h12);
    cmp_bit(nv_busy, 1'h1);
    wait_nv(n);
    cmp_bit(n <= host.NV_WAIT, 1'h1);
    chk_rd(8'ha1, 8'hf8);
    chk_rd(8'ha0, 8'h07);
    wdata = 8'($random(seed));
    wr(8'ha3, wdata);
    wait_nv(n);
    chk_rd(8'ha3, wdata & 8'hf8);
    wr(8'haa, 8'h12);
    wr(8'hab, 8'h3f);
    chk_rd(8'hab, 8'h38);
    cmp_word(result, 16'h1238);
    chk_rd(8'h55, 8'h00);
    $display("register access done");
    for (k = 0; k < 2; k++) begin
      host.pulse_low(k[0], 30);
      watch(k, 1'h0, seen);
      cmp_bit(seen, 1'h0);
      fork
        host.pulse_low(k[0], 300);
      join_none
      watch(k, 1'h0, seen);
      cmp_bit(seen, 1'h1);
    end
    $display("input filter done");
    report_and_stop();
  end
endmodule : testbench
